// File: src/adp_top.sv
/*
 Address decode for the 64-Kbyte CPU map plus the first ten I/O page
 locations: port A-C, E and F data latches, port D pin read and port A-C direction registers.
 Assumes the CPU bus master on i_clk with one-cycle strobes and read
 data taken the cycle after the read strobe; memories and other
 registers sit outside and use the registered selects.
*/
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "adp_cfg.svh"

module adp_top
   import adp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // CPU register bus
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Configuration from the option register
   input wire logic i_illegal_rst_en,
   // Direction of ports E and F, held elsewhere
   input wire logic [7:0] i_pte_dir,
   input wire logic [7:0] i_ptf_dir,
   // Pin levels, asynchronous
   input wire logic [7:0] i_pta_pin,
   input wire logic [7:0] i_ptb_pin,
   input wire logic [7:0] i_ptc_pin,
   input wire logic [7:0] i_ptd_pin,
   input wire logic [7:0] i_pte_pin,
   input wire logic [7:0] i_ptf_pin,
   // Region selects, registered
   output adp_pkg::adp_sel_t o_sel,
   output logic o_sel_wr,
   // Illegal address handling
   output logic o_illegal_rst_req,
   output logic o_illegal_flag,
   output logic [15:0] o_illegal_addr,
   // Port latches and directions to the pin logic
   output logic [7:0] o_pta_out,
   output logic [7:0] o_ptb_out,
   output logic [7:0] o_ptc_out,
   output logic [7:0] o_pte_out,
   output logic [7:0] o_ptf_out,
   output logic [7:0] o_pta_dir,
   output logic [7:0] o_ptb_dir,
   output logic [7:0] o_ptc_dir
);
   import adp_pkg::*;

   adp_state_t st_r;
   adp_state_t st_nxt;

   adp_sel_t dec_sel;
   logic dec_illegal;
   logic access;

   logic [7:0] pta_s;
   logic [7:0] ptb_s;
   logic [7:0] ptc_s;
   logic [7:0] ptd_s;
   logic [7:0] pte_s;
   logic [7:0] ptf_s;

   logic [7:0] pta_view;
   logic [7:0] ptb_view;
   logic [7:0] ptc_view;
   logic [7:0] pte_view;
   logic [7:0] ptf_view;
   logic [7:0] port_rd;

   // Decode is purely combinational; selects leave registered
   adp_decode u_decode (
      .i_addr(i_addr),
      .o_sel(dec_sel),
      .o_illegal(dec_illegal)
   );

   // Pins are asynchronous to the bus clock
   adp_sync2 #(.W(48)) u_pin_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_pta_pin, i_ptb_pin, i_ptc_pin, i_ptd_pin, i_pte_pin, i_ptf_pin}),
      .o_sync({pta_s, ptb_s, ptc_s, ptd_s, pte_s, ptf_s})
   );

   assign access = i_wr | i_rd;

   // Output bits read back the latch, input bits the pin
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_view
         assign pta_view[b] = st_r.port_a_direction[b] ?
                              st_r.port_a_output_latch[b] : pta_s[b];
         assign ptb_view[b] = st_r.port_b_direction[b] ?
                              st_r.port_b_output_latch[b] : ptb_s[b];
         assign ptc_view[b] = st_r.port_c_direction[b] ?
                              st_r.port_c_output_latch[b] : ptc_s[b];
         assign pte_view[b] = i_pte_dir[b] ? st_r.port_e_output_latch[b] : pte_s[b];
         assign ptf_view[b] = i_ptf_dir[b] ? st_r.port_f_output_latch[b] : ptf_s[b];
      end
   endgenerate

   // Read mux of the local port block
   always_comb begin
      port_rd = 8'h00;
      unique case (i_addr)
         `ADP_PTA_OFS: port_rd = pta_view;
         `ADP_PTB_OFS: port_rd = ptb_view;
         `ADP_PTC_OFS: port_rd = ptc_view & `ADP_PTC_MASK;
         `ADP_PTD_OFS: port_rd = ptd_s & `ADP_PTD_MASK;
         `ADP_PORT_A_DIRECTION_OFS: port_rd = st_r.port_a_direction;
         `ADP_PORT_B_DIRECTION_OFS: port_rd = st_r.port_b_direction;
         `ADP_PORT_C_DIRECTION_OFS: port_rd = st_r.port_c_direction & `ADP_PORT_C_DIRECTION_MASK;
         `ADP_PTE_OFS: port_rd = pte_view;
         `ADP_PTF_OFS: port_rd = ptf_view & `ADP_PTF_MASK;
         default: port_rd = 8'h00;
      endcase
   end

   always_comb begin
      st_nxt = st_r;

      // Selects and strobe kind stand for one cycle after the strobe
      st_nxt.sel = access ? dec_sel : '0;
      st_nxt.sel_wr = i_wr;

      // Read data only in the cycle after a read; port reads have no side effect
      st_nxt.rdata = 8'h00;
      if (i_rd && dec_sel[`ADP_SEL_PORT]) begin
         st_nxt.rdata = port_rd;
      end

      // Writes; port D and reserved bits take nothing
      if (i_wr && dec_sel[`ADP_SEL_PORT]) begin
         unique case (i_addr)
            `ADP_PTA_OFS: begin
               st_nxt.port_a_output_latch = i_wdata;
            end
            `ADP_PTB_OFS: begin
               st_nxt.port_b_output_latch = i_wdata;
            end
            `ADP_PTC_OFS: begin
               st_nxt.port_c_output_latch = i_wdata & `ADP_PTC_MASK;
            end
            `ADP_PORT_A_DIRECTION_OFS: begin
               st_nxt.port_a_direction = i_wdata;
            end
            `ADP_PORT_B_DIRECTION_OFS: begin
               st_nxt.port_b_direction = i_wdata;
            end
            `ADP_PORT_C_DIRECTION_OFS: begin
               st_nxt.port_c_direction = i_wdata & `ADP_PORT_C_DIRECTION_MASK;
            end
            `ADP_PTE_OFS: begin
               st_nxt.port_e_output_latch = i_wdata;
            end
            `ADP_PTF_OFS: begin
               st_nxt.port_f_output_latch = i_wdata & `ADP_PTF_MASK;
            end
            default: begin
               // Port D is pin state only
               st_nxt.port_a_output_latch = st_r.port_a_output_latch;
            end
         endcase
      end

      // Illegal access: flag always, reset request only when enabled
      st_nxt.ill_req = access & dec_illegal & i_illegal_rst_en;
      if (access && dec_illegal) begin
         st_nxt.ill_flag = 1'b1;
         st_nxt.ill_addr = i_addr;
      end
   end

   // Port latches keep their contents through reset on purpose
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r.port_a_direction <= `ADP_DIR_RST;
         st_r.port_b_direction <= `ADP_DIR_RST;
         st_r.port_c_direction <= `ADP_DIR_RST;
         st_r.rdata <= 8'h00;
         st_r.sel <= '0;
         st_r.sel_wr <= 1'b0;
         st_r.ill_req <= 1'b0;
         st_r.ill_flag <= 1'b0;
         st_r.ill_addr <= 16'h0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_sel = st_r.sel;
   assign o_sel_wr = st_r.sel_wr;
   assign o_illegal_rst_req = st_r.ill_req;
   assign o_illegal_flag = st_r.ill_flag;
   assign o_illegal_addr = st_r.ill_addr;
   assign o_pta_out = st_r.port_a_output_latch;
   assign o_ptb_out = st_r.port_b_output_latch;
   assign o_ptc_out = st_r.port_c_output_latch;
   assign o_pte_out = st_r.port_e_output_latch;
   assign o_ptf_out = st_r.port_f_output_latch;
   assign o_pta_dir = st_r.port_a_direction;
   assign o_ptb_dir = st_r.port_b_direction;
   assign o_ptc_dir = st_r.port_c_direction;

endmodule // adp_top

`default_nettype wire

// File: src/adp_cfg.svh
/*
 Address map, register offsets, field masks and select positions for the
 address decode and port register block. Definitions only.
*/
`ifndef ADP_CFG_SVH
`define ADP_CFG_SVH

// Region bounds of the 64-Kbyte map
`define ADP_IO_LO 16'h0000
`define ADP_IO_HI 16'h005f
`define ADP_RAM_LO 16'h0060
`define ADP_RAM_HI 16'h035f
`define ADP_UNIMP_LO 16'h0360
`define ADP_UNIMP_HI 16'h9fff
`define ADP_FLASH_LO 16'ha000
`define ADP_FLASH_HI 16'hfdff
`define ADP_RESET_CAUSE_STATUS_ADDR 16'hfe01
`define ADP_RSVD_LO 16'hfe02
`define ADP_RSVD_HI 16'hfe07
`define ADP_FLASH_PROGRAM_CONTROL_ADDR 16'hfe08
`define ADP_LVI_ADDR 16'hfe0f
`define ADP_MON_LO 16'hfe10
`define ADP_MON_HI 16'hfeff
`define ADP_FLASH_BLOCK_PROTECTION_ADDR 16'hff80
`define ADP_VECT_LO 16'hffd2
`define ADP_VECT_HI 16'hffff
`define ADP_COP_ADDR 16'hffff

// Port register offsets inside the I/O page
`define ADP_PTA_OFS 16'h0000
`define ADP_PTB_OFS 16'h0001
`define ADP_PTC_OFS 16'h0002
`define ADP_PTD_OFS 16'h0003
`define ADP_PORT_A_DIRECTION_OFS 16'h0004
`define ADP_PORT_B_DIRECTION_OFS 16'h0005
`define ADP_PORT_C_DIRECTION_OFS 16'h0006
`define ADP_HOLE_OFS 16'h0007
`define ADP_PTE_OFS 16'h0008
`define ADP_PTF_OFS 16'h0009

// Implemented-bit masks and reset values
`define ADP_PTC_MASK 8'h7f
`define ADP_PTD_MASK 8'h7f
`define ADP_PTF_MASK 8'h3f
`define ADP_PORT_C_DIRECTION_MASK 8'h7f
`define ADP_DIR_RST 8'h00

// One-hot select positions
`define ADP_SEL_W 12
`define ADP_SEL_PORT 0
`define ADP_SEL_IO 1
`define ADP_SEL_RAM 2
`define ADP_SEL_FLASH 3
`define ADP_SEL_RESET_CAUSE_STATUS 4
`define ADP_SEL_RSVD 5
`define ADP_SEL_FLASH_PROGRAM_CONTROL 6
`define ADP_SEL_LVI 7
`define ADP_SEL_MON 8
`define ADP_SEL_FLASH_BLOCK_PROTECTION 9
`define ADP_SEL_VECT 10
`define ADP_SEL_COP 11

`endif

// File: src/adp_pkg.sv
/*
 Types for the address decode and port register block.
 Assumes adp_cfg.svh is on the include path.
*/
`include "adp_cfg.svh"

package adp_pkg;

   typedef logic [`ADP_SEL_W-1:0] adp_sel_t;

   typedef struct packed {
      logic [7:0] port_a_output_latch;
      logic [7:0] port_b_output_latch;
      logic [7:0] port_c_output_latch;
      logic [7:0] port_e_output_latch;
      logic [7:0] port_f_output_latch;
      logic [7:0] port_a_direction;
      logic [7:0] port_b_direction;
      logic [7:0] port_c_direction;
      logic [7:0] rdata;
      adp_sel_t sel;
      logic sel_wr;
      logic ill_req;
      logic ill_flag;
      logic [15:0] ill_addr;
   } adp_state_t;

endpackage

// File: src/adp_decode.sv
/*
 Combinational address decoder: one-hot region select or illegal flag.
 Assumes a 16-bit address that is stable while a strobe is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adp_cfg.svh"

module adp_decode
   import adp_pkg::*;
(
   // Address
   input wire logic [15:0] i_addr,
   // Decode result
   output adp_pkg::adp_sel_t o_sel,
   output logic o_illegal
);
   import adp_pkg::*;

   always_comb begin
      o_sel = '0;
      o_illegal = 1'b0;
      if (i_addr <= `ADP_PTF_OFS) begin
         if (i_addr == `ADP_HOLE_OFS) begin
            o_illegal = 1'b1;
         end else begin
            o_sel[`ADP_SEL_PORT] = 1'b1;
         end
      end else if (i_addr <= `ADP_IO_HI) begin
         o_sel[`ADP_SEL_IO] = 1'b1;
      end else if (i_addr <= `ADP_RAM_HI) begin
         o_sel[`ADP_SEL_RAM] = 1'b1;
      end else if (i_addr <= `ADP_UNIMP_HI) begin
         o_illegal = 1'b1;
      end else if (i_addr <= `ADP_FLASH_HI) begin
         o_sel[`ADP_SEL_FLASH] = 1'b1;
      end else if (i_addr == `ADP_RESET_CAUSE_STATUS_ADDR) begin
         o_sel[`ADP_SEL_RESET_CAUSE_STATUS] = 1'b1;
      end else if (i_addr >= `ADP_RSVD_LO && i_addr <= `ADP_RSVD_HI) begin
         o_sel[`ADP_SEL_RSVD] = 1'b1;
      end else if (i_addr == `ADP_FLASH_PROGRAM_CONTROL_ADDR) begin
         o_sel[`ADP_SEL_FLASH_PROGRAM_CONTROL] = 1'b1;
      end else if (i_addr == `ADP_LVI_ADDR) begin
         o_sel[`ADP_SEL_LVI] = 1'b1;
      end else if (i_addr >= `ADP_MON_LO && i_addr <= `ADP_MON_HI) begin
         o_sel[`ADP_SEL_MON] = 1'b1;
      end else if (i_addr == `ADP_FLASH_BLOCK_PROTECTION_ADDR) begin
         o_sel[`ADP_SEL_FLASH_BLOCK_PROTECTION] = 1'b1;
      end else if (i_addr == `ADP_COP_ADDR) begin
         // Watchdog wins over the vector it overlays
         o_sel[`ADP_SEL_COP] = 1'b1;
      end else if (i_addr >= `ADP_VECT_LO) begin
         o_sel[`ADP_SEL_VECT] = 1'b1;
      end else begin
         // $FE00, $FE09-$FE0E, $FF00-$FF7F, $FF81-$FFD1
         o_illegal = 1'b1;
      end
   end

endmodule // adp_decode

`default_nettype wire

// File: src/adp_sync2.sv
/*
 Two flip-flop synchroniser for a group of pin inputs.
 Assumes each bit is an independent level; no bus coherence.
*/
`timescale 1ns/1ns
`default_nettype none

module adp_sync2 #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pins in, synchronised out
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } adp_sync_t;

   adp_sync_t st_r;
   adp_sync_t st_nxt;

   always_comb begin
      st_nxt.meta = i_async;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.stable;

endmodule // adp_sync2

`default_nettype wire

// File: bench/adp_top_monitor.sv
/*
 Checker for the address decode block: selects, illegal flagging, read data.
 Assumes it is bound to adp_top and sees only that module's ports.
*/
`timescale 1ns/1ns
`default_nettype none

module adp_top_monitor
   import adp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Bus side
   input wire logic [15:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_illegal_rst_en,
   input wire logic [7:0] o_rdata,
   // Decode results
   input wire adp_pkg::adp_sel_t o_sel,
   input wire logic o_sel_wr,
   input wire logic o_illegal_rst_req,
   input wire logic o_illegal_flag,
   input wire logic [15:0] o_illegal_addr,
   input wire logic [7:0] o_ptc_dir
);
   wire bus = i_wr | i_rd;
   // Written apart from the design's decoder so a shared slip cannot hide
   wire ill = i_addr == 16'h0007 || (i_addr >= 16'h0360 && i_addr <= 16'h9fff) ||
      i_addr == 16'hfe00 || (i_addr >= 16'hfe09 && i_addr <= 16'hfe0e) ||
      (i_addr >= 16'hff00 && i_addr <= 16'hffd1 && i_addr != 16'hff80);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_onehot;
      bus && !ill |=> $onehot(o_sel);
   endproperty
   a_onehot: assert property (p_onehot) else $error("legal access without one select");
   property p_ill_nosel;
      bus && ill |=> o_sel == '0 && o_illegal_flag;
   endproperty
   a_ill_nosel: assert property (p_ill_nosel) else $error("illegal access unflagged");
   property p_req_on;
      bus && ill && i_illegal_rst_en |=> o_illegal_rst_req;
   endproperty
   a_req_on: assert property (p_req_on) else $error("reset request missing");
   property p_req_off;
      !(bus && ill && i_illegal_rst_en) |=> !o_illegal_rst_req;
   endproperty
   a_req_off: assert property (p_req_off) else $error("spurious reset request");
   property p_ill_addr;
      bus && ill |=> o_illegal_addr == $past(i_addr);
   endproperty
   a_ill_addr: assert property (p_ill_addr) else $error("illegal address not held");
   property p_sticky;
      o_illegal_flag |=> o_illegal_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("illegal flag dropped");
   property p_ram;
      bus && i_addr >= 16'h0060 && i_addr <= 16'h035f |=> o_sel == 12'h004;
   endproperty
   a_ram: assert property (p_ram) else $error("ram select wrong");
   property p_cop;
      bus && i_addr == 16'hffff |=> o_sel == 12'h800;
   endproperty
   a_cop: assert property (p_cop) else $error("watchdog select wrong");
   property p_idle;
      !bus |=> o_sel == '0 && !o_sel_wr;
   endproperty
   a_idle: assert property (p_idle) else $error("select without strobe");
   property p_wr_qual;
      bus |=> o_sel_wr == $past(i_wr) && (!o_sel_wr || o_rdata == 8'h00) ##1
         o_sel_wr == $past(i_wr);
   endproperty
   a_wr_qual: assert property (p_wr_qual) else $error("write qualifier wrong");
   property p_rd_quiet;
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
   property p_dirc7;
      o_ptc_dir[7] == 1'b0;
   endproperty
   a_dirc7: assert property (p_dirc7) else $error("direction C bit 7 set");

   c_ill_rst: cover property (bus && ill && i_illegal_rst_en);
   c_b2b: cover property (i_wr ##1 i_rd);
   c_cop: cover property (i_rd && i_addr == 16'hffff);
endmodule // adp_top_monitor

bind adp_top adp_top_monitor i_mon (.i_clk, .i_rst_n, .i_addr, .i_wr, .i_rd,
   .i_illegal_rst_en, .o_rdata, .o_sel, .o_sel_wr, .o_illegal_rst_req,
   .o_illegal_flag, .o_illegal_addr, .o_ptc_dir);

`default_nettype wire

// File: bench/adp_cpu_model.sv
/*
 Behavioural CPU bus master for the decode block.
 Assumes one clock; callers start each task right after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module adp_cpu_model (
   // Clock
   input wire logic i_clk,
   // Bus toward the decoder
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [7:0] i_rdata
);
   initial begin
      o_addr = 16'h0000;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Inverted leftovers so a stale value is never mistaken for a fresh one
   task automatic release_bus();
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
   endtask
   task automatic idle();
      @(posedge i_clk);
      release_bus();
   endtask
   // Strobe raised for all but fe02-fe07 and left up, so calls run back to back until rd or idle
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_rd <= 1'b0;
      o_wr <= !(a >= 16'hfe02 && a <= 16'hfe07);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      @(posedge i_clk);
      release_bus();
      #1 d = i_rdata;
   endtask
endmodule // adp_cpu_model

`default_nettype wire

// File: bench/adp_top_tb.sv
/*
 Self-checking bench: port registers with random data, map sweep, resets.
 Assumes adp_cpu_model as bus master and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none

module adp_top_tb;
   import adp_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic en = 1'b0;
   logic [7:0] pte_dir = 8'h00;
   logic [7:0] ptf_dir = 8'h00;
   logic [5:0][7:0] pin = '0;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   adp_sel_t sel;
   logic req;
   logic flag;
   logic [15:0] iaddr;
   logic [7:0][7:0] po;
   logic [7:0] reg_m [10];
   logic [9:0][7:0] msk = {8'h3f, 8'hff, 8'h00, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'hff};
   int amap [8] = '{0, 1, 2, 8, 9, 4, 5, 6};
   logic [23:0] map [29] = '{24'h000000, 24'h000900, 24'h0007ff, 24'h000a01, 24'h005f01,
      24'h006002, 24'h035f02, 24'h0360ff, 24'h9fffff, 24'ha00003, 24'hfdff03, 24'hfe00ff,
      24'hfe0104, 24'hfe0205, 24'hfe0705, 24'hfe0806, 24'hfe09ff, 24'hfe0eff, 24'hfe0f07,
      24'hfe1008, 24'hfeff08, 24'hff00ff, 24'hff7fff, 24'hff8009, 24'hff81ff, 24'hffd1ff,
      24'hffd20a, 24'hfffe0a, 24'hffff0b};
   logic [7:0] d;
   logic ill;
   int num_errors = 0;
   int n_checks = 0;

   always #25 i_clk = ~i_clk;

   adp_cpu_model i_cpu (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd), .i_rdata(rdata));
   adp_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_illegal_rst_en(en), .i_pte_dir(pte_dir),
      .i_ptf_dir(ptf_dir), .i_pta_pin(pin[0]), .i_ptb_pin(pin[1]), .i_ptc_pin(pin[2]),
      .i_ptd_pin(pin[3]), .i_pte_pin(pin[4]), .i_ptf_pin(pin[5]), .o_sel(sel),
      .o_sel_wr(), .o_illegal_rst_req(req), .o_illegal_flag(flag), .o_illegal_addr(iaddr),
      .o_pta_out(po[0]), .o_ptb_out(po[1]), .o_ptc_out(po[2]), .o_pte_out(po[3]),
      .o_ptf_out(po[4]), .o_pta_dir(po[5]), .o_ptb_dir(po[6]), .o_ptc_dir(po[7]));

   // Output bits follow the latch, input bits the pin
   function automatic logic [7:0] exp_rd(input int a);
      logic [7:0] dir;
      logic [7:0] pi;
      if (a >= 4 && a <= 7) return reg_m[a] & msk[a];
      dir = a == 3 ? 8'h00 : a == 8 ? pte_dir : a == 9 ? ptf_dir : reg_m[a + 4];
      pi = a < 4 ? pin[a] : pin[a - 4];
      return ((reg_m[a] & dir) | (pi & ~dir)) & msk[a];
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: data %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: word %h want %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Directions must read back zero after every reset
   task automatic do_reset();
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int a = 4; a < 7; a++) begin
         i_cpu.rd(16'(a), d);
         reg_m[a] = 8'h00;
         chk8(d, 8'h00);
      end
      chk8({7'h00, flag}, 8'h00);
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      $display("mismatch at %0t: run hung", $time);
      close_out();
   end

   initial begin
      void'($urandom(32'hc57c));
      do_reset();
      $display("test reset done, errors %0d", num_errors);
      for (int k = 0; k < 16; k++) begin
         @(posedge i_clk);
         pin <= 48'({$urandom, $urandom});
         pte_dir <= 8'($urandom);
         ptf_dir <= 8'($urandom);
         // Back-to-back writes, including read-only D and the hole at 7
         for (int a = 0; a < 10; a++) begin
            d = 8'($urandom);
            // Reserved bits left 0; port D kept whole as the read-only case
            if (a != 3) d &= msk[a];
            i_cpu.wr(16'(a), d);
            if (a != 3 && a != 7) reg_m[a] = d & msk[a];
         end
         for (int a = 0; a < 10; a++) begin
            i_cpu.rd(16'(a), d);
            chk8(d, exp_rd(a));
         end
         for (int j = 0; j < 8; j++)
            chk8(po[j], reg_m[amap[j]]);
      end
      $display("test ports done, errors %0d", num_errors);
      for (int i = 0; i < 29; i++) begin
         @(posedge i_clk);
         en <= i[0];
         i_cpu.rd(map[i][23:8], d);
         ill = map[i][7:0] == 8'hff;
         chk16(16'(sel), ill ? 16'h0000 : 16'h0001 << map[i][7:0]);
         chk8({7'h00, req}, {7'h00, ill & en});
         if (ill)
            chk16(iaddr, map[i][23:8]);
      end
      $display("test map done, errors %0d", num_errors);
      do_reset();
      for (int j = 0; j < 5; j++)
         chk8(po[j], reg_m[amap[j]]);
      $display("test second reset done, errors %0d", num_errors);
      close_out();
   end
endmodule // adp_top_tb

`default_nettype wire
